// [logic/tocr_apb_if.sv]
/*
 * Internal carrier between the register front and the offset adder.
 * Assumes both ends run on pclk.
 */
`timescale 1ns/1ps
interface tocr_apb_if;
    logic signed [7:0] offset;
    logic        [7:0] raw_temp;
    logic              raw_valid;
    logic        [7:0] corr_temp;
    logic              corr_valid;
    modport regs  (output offset, output raw_temp, output raw_valid,
                   input corr_temp, input corr_valid);
    modport adder (input offset, input raw_temp, input raw_valid,
                   output corr_temp, output corr_valid);
endinterface

// [logic/tocr_offset_add.sv]
/*
 * Applies a signed half-degree offset to a raw temperature code before it
 * is stored, with saturation. Assumes raw code is offset-binary, 0.5 C lsb.
 */
`timescale 1ns/1ps
module tocr_offset_add
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    tocr_apb_if.adder  link
);
    import tocr_pkg::*;

    typedef struct packed {
        logic [7:0] corr;
        logic       vld;
    } tocr_add_state_type;

    tocr_add_state_type s_q;
    tocr_add_state_type s_d;
    logic signed [9:0]  sum;

    // sign-extended add, clamped so wrap never flips hot into cold
    always_comb
    begin
        sum = $signed({2'b00, link.raw_temp}) + 10'(link.offset);
        s_d = s_q;
        s_d.vld = link.raw_valid;
        if (link.raw_valid)
        begin
            if (sum < 0)
                s_d.corr = 8'h00;
            else if (sum > 10'sd255)
                s_d.corr = 8'hff;
            else
                s_d.corr = sum[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign link.corr_temp  = s_q.corr;
    assign link.corr_valid = s_q.vld;
endmodule

// [logic/tocr_pkg.sv]
/*
 * Shared constants and types for the temperature offset and configuration
 * register block: register word indices, field positions, reset values, codes.
 * Assumes a 32-bit APB bus with 8-bit registers held in the low byte.
 */
package tocr_pkg;

    // register word indices; the bus byte address is four times the index
    localparam logic [7:0]  IDX_LOCAL_OFFSET   = 8'h71;
    localparam logic [7:0]  IDX_REMOTE2_OFFSET = 8'h72;
    localparam logic [7:0]  IDX_MEAS_CONFIG2   = 8'h73;
    localparam logic [7:0]  IDX_CHAN_SELECT    = 8'h55;
    localparam logic [7:0]  IDX_DUTY_CH1       = 8'h30;
    localparam logic [7:0]  IDX_DUTY_CH2       = 8'h31;
    localparam logic [7:0]  IDX_DUTY_CH3       = 8'h32;
    localparam logic [7:0]  IDX_LOCK_CTRL      = 8'h40;
    localparam logic [7:0]  IDX_TEMP_RESULT    = 8'h25;

    // configuration two, channel select and lock control field positions
    localparam int CFG2_DETECT_EN_BIT  = 0;
    localparam int CFG2_FOUND_LO_BIT   = 1;
    localparam int CFG2_AVG_DIS_BIT    = 4;
    localparam int CFG2_INPUT_ATTENUATOR_BYPASS_BIT       = 5;
    localparam int CFG2_SINGLE_BIT     = 6;
    localparam int CFG2_SHUTDOWN_CONTROL_BIT       = 7;
    localparam int CHSEL_LO_BIT        = 5;
    localparam int LOCK_BIT            = 0;
    localparam int INV_BIT             = 1;

    // reset values, and the duty value read back in shutdown
    localparam logic [7:0] OFFSET_RESET   = 8'h00;
    localparam logic [7:0] CONFIG2_RESET  = 8'h00;
    localparam logic [7:0] CHSEL_RESET    = 8'h00;
    localparam logic [7:0] DUTY_RESET     = 8'h00;
    localparam logic [7:0] DUTY_SHUTDOWN_CONTROL_READ = 8'h00;
    localparam logic [4:0] CHEN_ALL       = 5'h1f;

    // single-channel select codes
    typedef enum logic [2:0] {
        CH_RSVD0   = 3'b000,
        CH_CORE    = 3'b001,
        CH_MAIN    = 3'b010,
        CH_RSVD3   = 3'b011,
        CH_RSVD4   = 3'b100,
        CH_REMOTE1 = 3'b101,
        CH_LOCAL   = 3'b110,
        CH_REMOTE2 = 3'b111
    } tocr_chan_type;

    // one-hot channel enables for the converter sequencer
    localparam int NUM_SINGLE_CHANNEL_MODE_CH = 5;

endpackage

// [logic/tocr_regs.sv]
/*
 * APB register bank: local and remote-2 temperature offsets, configuration
 * two with fan detect, averaging, attenuator, single-channel and shutdown.
 * Assumes the converter supplies raw readings with a channel tag and fan
 * presence arrives from pins in another domain (synchronised here).
 */
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module tocr_regs
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [9:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [2:0]             four_wire_sense,
    input  wire logic [7:0]             raw_temp,
    input  wire logic                   raw_valid,
    input  wire tocr_pkg::tocr_chan_type raw_chan,
    input  wire logic [2:0]             fan_pwm_raw,
    output logic      [2:0]             fan_drive,
    output logic                        averaging_disable,
    output logic                        input_attenuator_bypass,
    output logic                        single_channel_mode,
    output logic      [4:0]             single_channel_mode_chan_enable,
    output logic      [7:0]             local_temp_q,
    output logic      [7:0]             remote2_temp_q
);
    import tocr_pkg::*;

    typedef struct packed {
        logic [7:0]  loc_off;
        logic [7:0]  rem2_off;
        logic [7:0]  cfg2;
        logic [7:0]  chsel;
        logic [2:0]  duty_src;
        logic [23:0] duty;
        logic        lock;
        logic        drive_polarity_invert;
        logic [2:0]  sense_m;
        logic [2:0]  sense_s;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic [2:0]  drive;
        logic [4:0]  chen;
        logic [7:0]  loc_t;
        logic [7:0]  rem2_t;
        logic [2:0]  pend_chan;
    } tocr_state_type;

    tocr_state_type s_q;
    tocr_state_type s_d;
    logic [7:0]     widx;
    logic           mapped;
    logic           acc;
    logic           done;
    logic           wr;
    logic           rd;

    tocr_apb_if     add_link ();

    // decodes an address into a mapped flag, shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == IDX_LOCAL_OFFSET) || (a == IDX_REMOTE2_OFFSET) ||
                    (a == IDX_MEAS_CONFIG2) || (a == IDX_CHAN_SELECT) ||
                    (a == IDX_DUTY_CH1) || (a == IDX_DUTY_CH2) ||
                    (a == IDX_DUTY_CH3) || (a == IDX_LOCK_CTRL) ||
                    (a == IDX_TEMP_RESULT);
    endfunction

    // channel code to sequencer enable; reserved codes enable nothing
    function automatic logic [4:0] chan_decode(input logic [2:0] c);
        case (c)
            CH_CORE:    chan_decode = 5'h01;
            CH_MAIN:    chan_decode = 5'h02;
            CH_REMOTE1: chan_decode = 5'h04;
            CH_LOCAL:   chan_decode = 5'h08;
            CH_REMOTE2: chan_decode = 5'h10;
            default:    chan_decode = 5'h00;
        endcase
    endfunction

    // registers sit on aligned words; a write lands only on the pready edge
    assign widx   = paddr[9:2];
    assign mapped = is_mapped(widx) && (paddr[1:0] == 2'b00);
    assign acc    = psel && penable && !s_q.ready;
    assign done   = psel && penable && s_q.ready;
    assign wr     = done && pwrite && mapped;
    assign rd     = acc && !pwrite && mapped;

    // offset adder sees the offset of whichever channel is arriving
    assign add_link.offset    = (raw_chan == CH_LOCAL) ? s_q.loc_off : s_q.rem2_off;
    assign add_link.raw_temp  = raw_temp;
    assign add_link.raw_valid = raw_valid &&
                                (raw_chan == CH_LOCAL || raw_chan == CH_REMOTE2);

    tocr_offset_add u_add
    (
        .pclk    (pclk),
        .presetn (presetn),
        .link    (add_link)
    );

    // next-state logic for bus slave, registers and control outputs
    always_comb
    begin
        s_d = s_q;
        s_d.sense_m = four_wire_sense;
        s_d.sense_s = s_q.sense_m;
        s_d.ready = acc;
        s_d.err = acc && !mapped;
        s_d.rdata = 32'h0000_0000;
        // found bits are refreshed only while detection is enabled
        if (s_q.cfg2[CFG2_DETECT_EN_BIT])
            s_d.cfg2[3:1] = s_q.sense_s;
        if (wr)
        begin
            case (widx)
                IDX_LOCAL_OFFSET:
                    if (!s_q.lock) s_d.loc_off = pwdata[7:0];
                IDX_REMOTE2_OFFSET:
                    if (!s_q.lock) s_d.rem2_off = pwdata[7:0];
                IDX_MEAS_CONFIG2:
                begin
                    s_d.cfg2[CFG2_DETECT_EN_BIT] = pwdata[CFG2_DETECT_EN_BIT];
                    s_d.cfg2[7:4] = pwdata[7:4];
                end
                IDX_CHAN_SELECT:  s_d.chsel = pwdata[7:0];
                IDX_DUTY_CH1:     s_d.duty[7:0] = pwdata[7:0];
                IDX_DUTY_CH2:     s_d.duty[15:8] = pwdata[7:0];
                IDX_DUTY_CH3:     s_d.duty[23:16] = pwdata[7:0];
                // lock is sticky until reset
                IDX_LOCK_CTRL:
                begin
                    s_d.lock = s_q.lock | pwdata[LOCK_BIT];
                    s_d.drive_polarity_invert = pwdata[INV_BIT];
                end
                default: ;
            endcase
        end
        if (rd)
        begin
            case (widx)
                IDX_LOCAL_OFFSET:   s_d.rdata = {24'h0, s_q.loc_off};
                IDX_REMOTE2_OFFSET: s_d.rdata = {24'h0, s_q.rem2_off};
                IDX_MEAS_CONFIG2:   s_d.rdata = {24'h0, s_q.cfg2};
                IDX_CHAN_SELECT:    s_d.rdata = {24'h0, s_q.chsel};
                IDX_DUTY_CH1:       s_d.rdata = {24'h0, s_q.cfg2[CFG2_SHUTDOWN_CONTROL_BIT] ?
                                                 DUTY_SHUTDOWN_CONTROL_READ : s_q.duty[7:0]};
                IDX_DUTY_CH2:       s_d.rdata = {24'h0, s_q.cfg2[CFG2_SHUTDOWN_CONTROL_BIT] ?
                                                 DUTY_SHUTDOWN_CONTROL_READ : s_q.duty[15:8]};
                IDX_DUTY_CH3:       s_d.rdata = {24'h0, s_q.cfg2[CFG2_SHUTDOWN_CONTROL_BIT] ?
                                                 DUTY_SHUTDOWN_CONTROL_READ : s_q.duty[23:16]};
                IDX_LOCK_CTRL:      s_d.rdata = {30'h0, s_q.drive_polarity_invert, s_q.lock};
                IDX_TEMP_RESULT:    s_d.rdata = {16'h0, s_q.rem2_t, s_q.loc_t};
                default:            s_d.rdata = 32'h0000_0000;
            endcase
        end
        // shutdown holds every fan at its off level
        if (s_q.cfg2[CFG2_SHUTDOWN_CONTROL_BIT])
            s_d.drive = {3{s_q.drive_polarity_invert}};
        else
            s_d.drive = fan_pwm_raw ^ {3{s_q.drive_polarity_invert}};
        // single-channel mode restricts sequencer to the chosen input
        if (s_q.cfg2[CFG2_SINGLE_BIT])
            s_d.chen = chan_decode(s_q.chsel[7:CHSEL_LO_BIT]);
        else
            s_d.chen = CHEN_ALL;
        // corrected readings are stored two cycles after the raw sample
        s_d.pend_chan = raw_chan;
        if (add_link.corr_valid)
        begin
            if (s_q.pend_chan == CH_LOCAL)
                s_d.loc_t = add_link.corr_temp;
            else
                s_d.rem2_t = add_link.corr_temp;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.loc_off <= OFFSET_RESET;
            s_q.rem2_off <= OFFSET_RESET;
            s_q.cfg2 <= CONFIG2_RESET;
            s_q.chsel <= CHSEL_RESET;
            s_q.duty <= {3{DUTY_RESET}};
            s_q.chen <= CHEN_ALL;
        end
        else
            s_q <= s_d;
    end

    assign prdata                  = s_q.rdata;
    assign pready                  = s_q.ready;
    assign pslverr                 = s_q.err;
    assign fan_drive               = s_q.drive;
    assign averaging_disable       = s_q.cfg2[CFG2_AVG_DIS_BIT];
    assign input_attenuator_bypass = s_q.cfg2[CFG2_INPUT_ATTENUATOR_BYPASS_BIT];
    assign single_channel_mode     = s_q.cfg2[CFG2_SINGLE_BIT];
    assign single_channel_mode_chan_enable        = s_q.chen;
    assign local_temp_q            = s_q.loc_t;
    assign remote2_temp_q          = s_q.rem2_t;

    // locked offsets never change on a write
    property p_lock_hold;
        @(posedge pclk) disable iff (!presetn)
        (s_q.lock && wr) |=> $stable(s_q.loc_off) && $stable(s_q.rem2_off);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("offset changed while locked");

    property p_unlocked_write;
        @(posedge pclk) disable iff (!presetn)
        (!s_q.lock && wr && widx == IDX_LOCAL_OFFSET) |=> s_q.loc_off == $past(pwdata[7:0]);
    endproperty
    a_unlocked_write: assert property (p_unlocked_write) else $error("offset write lost");

    property p_shutdown_control_drive;
        @(posedge pclk) disable iff (!presetn)
        s_q.cfg2[CFG2_SHUTDOWN_CONTROL_BIT] |=> fan_drive == {3{$past(s_q.drive_polarity_invert)}};
    endproperty
    a_shutdown_control_drive: assert property (p_shutdown_control_drive) else $error("fan not off in shutdown");

    property p_shutdown_control_duty;
        @(posedge pclk) disable iff (!presetn)
        (rd && widx == IDX_DUTY_CH1 && s_q.cfg2[CFG2_SHUTDOWN_CONTROL_BIT]) |=> prdata == 32'h0;
    endproperty
    a_shutdown_control_duty: assert property (p_shutdown_control_duty) else $error("duty nonzero in shutdown");

    property p_found_ro;
        @(posedge pclk) disable iff (!presetn)
        !s_q.cfg2[CFG2_DETECT_EN_BIT] |=> $stable(s_q.cfg2[3:1]);
    endproperty
    a_found_ro: assert property (p_found_ro) else $error("found bits changed");

    property p_detect;
        @(posedge pclk) disable iff (!presetn)
        s_q.cfg2[CFG2_DETECT_EN_BIT] |=> s_q.cfg2[3:1] == $past(s_q.sense_s);
    endproperty
    a_detect: assert property (p_detect) else $error("found bits not tracking");

    property p_single_local;
        @(posedge pclk) disable iff (!presetn)
        (s_q.cfg2[CFG2_SINGLE_BIT] && s_q.chsel[7:5] == 3'b110) |=> single_channel_mode_chan_enable == 5'h08;
    endproperty
    a_single_local: assert property (p_single_local) else $error("wrong channel");

    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        (s_q.cfg2[CFG2_SINGLE_BIT] && s_q.chsel[7:5] == 3'b000) |=> single_channel_mode_chan_enable == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code enabled");

    property p_ctrl_out;
        @(posedge pclk) disable iff (!presetn)
        (wr && widx == IDX_MEAS_CONFIG2) |=>
            averaging_disable == $past(pwdata[CFG2_AVG_DIS_BIT]) &&
            input_attenuator_bypass == $past(pwdata[CFG2_INPUT_ATTENUATOR_BYPASS_BIT]);
    endproperty
    a_ctrl_out: assert property (p_ctrl_out) else $error("control out mismatch");

    // every access phase is answered by exactly one registered pready pulse
    sequence s_access_start;
        psel && penable && !pready;
    endsequence

    sequence s_single_pulse;
        pready ##1 !pready;
    endsequence

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        s_access_start |=> s_single_pulse;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready not a single pulse");

    // lock can only be cleared by reset, otherwise offsets could be reopened
    property p_lock_sticky;
        @(posedge pclk) disable iff (!presetn)
        s_q.lock |=> s_q.lock;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock released");

    property p_remote2_write;
        @(posedge pclk) disable iff (!presetn)
        (!s_q.lock && wr && widx == IDX_REMOTE2_OFFSET) |=> s_q.rem2_off == $past(pwdata[7:0]);
    endproperty
    a_remote2_write: assert property (p_remote2_write) else $error("remote2 write lost");

    property p_single_off;
        @(posedge pclk) disable iff (!presetn)
        !s_q.cfg2[CFG2_SINGLE_BIT] |=> single_channel_mode_chan_enable == CHEN_ALL;
    endproperty
    a_single_off: assert property (p_single_off) else $error("sequencer not cycling");
endmodule

// [tb/tb_temp_offset_and_config_regs.sv]
/*
 * Self-checking bench for the temperature offset and configuration register
 * bank, driven over APB with directed reads, writes and converter samples.
 * Assumes the bank answers each access with a single-cycle pready pulse.
 */
`timescale 1ns/1ps
module tb_temp_offset_and_config_regs;
    import tocr_pkg::*;

    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [9:0]    paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic [2:0]    four_wire_sense;
    logic [7:0]    raw_temp;
    logic          raw_valid;
    tocr_chan_type raw_chan;
    logic [2:0]    fan_pwm_raw;
    logic [2:0]    fan_drive;
    logic          averaging_disable;
    logic          input_attenuator_bypass;
    logic          single_channel_mode;
    logic [4:0]    single_channel_mode_chan_enable;
    logic [7:0]    local_temp_q;
    logic [7:0]    remote2_temp_q;
    int            errors;
    int            checked;
    logic [31:0]   rd;
    logic          er;
    logic [4:0]    exp_en [8] = '{5'h00, 5'h01, 5'h02, 5'h00, 5'h00, 5'h04, 5'h08, 5'h10};

    tocr_regs u_dut
    (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .psel                    (psel),
        .penable                 (penable),
        .pwrite                  (pwrite),
        .paddr                   (paddr),
        .pwdata                  (pwdata),
        .prdata                  (prdata),
        .pready                  (pready),
        .pslverr                 (pslverr),
        .four_wire_sense         (four_wire_sense),
        .raw_temp                (raw_temp),
        .raw_valid               (raw_valid),
        .raw_chan                (raw_chan),
        .fan_pwm_raw             (fan_pwm_raw),
        .fan_drive               (fan_drive),
        .averaging_disable       (averaging_disable),
        .input_attenuator_bypass (input_attenuator_bypass),
        .single_channel_mode     (single_channel_mode),
        .single_channel_mode_chan_enable        (single_channel_mode_chan_enable),
        .local_temp_q            (local_temp_q),
        .remote2_temp_q          (remote2_temp_q)
    );

    // 25 MHz bus clock
    always #20 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // one APB transfer to register index a; a dead slave is left to the watchdog
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {a, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        check(n < 50, 1'b1, "pready late");
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0000_0000);
        check(er, 1'b0, msg);
        check(rd, exp, msg);
    endtask

    // one converter sample, then long enough for the adder and store stages
    task automatic sample(input tocr_chan_type c, input logic [7:0] t);
        @(posedge pclk);
        raw_valid <= 1'b1;
        raw_chan  <= c;
        raw_temp  <= t;
        @(posedge pclk);
        raw_valid <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge pclk);
        errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0000_0000;
        four_wire_sense = 3'b101;
        raw_temp = 8'h00;
        raw_valid = 1'b0;
        raw_chan = CH_RSVD0;
        fan_pwm_raw = 3'b101;
        errors = 0;
        checked = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;

        // power-on values of both offsets, config two, the control outputs and the channel enables
        rd_chk(IDX_LOCAL_OFFSET, 32'h0, "local offset reset");
        rd_chk(IDX_REMOTE2_OFFSET, 32'h0, "remote2 offset reset");
        rd_chk(IDX_MEAS_CONFIG2, 32'h0, "config two reset");
        @(negedge pclk);
        check({averaging_disable, input_attenuator_bypass, single_channel_mode}, 3'b000, "ctl reset");
        check(single_channel_mode_chan_enable, 5'h1f, "all channels at reset");
        $display("test reset done");

        // signed offsets applied before the reading is stored, with clamping
        apb(1'b1, IDX_LOCAL_OFFSET, 32'h0000_00fe);
        apb(1'b1, IDX_REMOTE2_OFFSET, 32'h0000_0003);
        rd_chk(IDX_LOCAL_OFFSET, 32'h0000_00fe, "local offset rw");
        rd_chk(IDX_REMOTE2_OFFSET, 32'h0000_0003, "remote2 offset rw");
        sample(CH_LOCAL, 8'h50);
        check(local_temp_q, 8'h4e, "negative local offset");
        sample(CH_REMOTE2, 8'h10);
        check(remote2_temp_q, 8'h13, "positive remote2 offset");
        rd_chk(IDX_TEMP_RESULT, 32'h0000_134e, "stored corrected pair");
        sample(CH_LOCAL, 8'h01);
        check(local_temp_q, 8'h00, "clamped below zero");
        sample(CH_REMOTE1, 8'h77);
        check({remote2_temp_q, local_temp_q}, 16'h1300, "other channel untouched");
        $display("test offsets done");

        // control bits and fan presence, found bits not writable
        apb(1'b1, IDX_MEAS_CONFIG2, 32'h0000_007f);
        repeat (5) @(posedge pclk);
        rd_chk(IDX_MEAS_CONFIG2, 32'h0000_007b, "found bits follow sense");
        @(negedge pclk);
        check({averaging_disable, input_attenuator_bypass, single_channel_mode}, 3'b111, "ctl");
        apb(1'b1, IDX_MEAS_CONFIG2, 32'h0000_0070);
        four_wire_sense <= 3'b010;
        repeat (5) @(posedge pclk);
        rd_chk(IDX_MEAS_CONFIG2, 32'h0000_007a, "found bits read-only, held");
        apb(1'b1, IDX_MEAS_CONFIG2, 32'h0000_0041);
        repeat (5) @(posedge pclk);
        rd_chk(IDX_MEAS_CONFIG2, 32'h0000_0045, "found bits refreshed");
        @(negedge pclk);
        check({averaging_disable, input_attenuator_bypass}, 2'b00, "ctl cleared");
        $display("test config two done");

        // every channel select code in single-channel mode
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, IDX_CHAN_SELECT, {24'h0, c[2:0], 5'h00});
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            check(single_channel_mode_chan_enable, exp_en[c], "channel select code");
        end
        rd_chk(IDX_CHAN_SELECT, 32'h0000_00e0, "select field");
        apb(1'b1, IDX_MEAS_CONFIG2, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check(single_channel_mode_chan_enable, 5'h1f, "cycling all channels");
        $display("test channel select done");

        // shutdown forces fans off in either polarity and hides duty
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, IDX_DUTY_CH1 + 8'(i), 32'h0000_0080 + 32'(i));
            rd_chk(IDX_DUTY_CH1 + 8'(i), 32'h0000_0080 + 32'(i), "duty before shutdown");
        end
        @(negedge pclk);
        check(fan_drive, 3'b101, "drive follows pwm");
        apb(1'b1, IDX_MEAS_CONFIG2, 32'h0000_0080);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check(fan_drive, 3'b000, "off level low");
        for (int i = 0; i < 3; i++)
            rd_chk(IDX_DUTY_CH1 + 8'(i), DUTY_SHUTDOWN_CONTROL_READ, "duty in shutdown");
        apb(1'b1, IDX_LOCK_CTRL, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check(fan_drive, 3'b111, "off level inverted");
        apb(1'b1, IDX_MEAS_CONFIG2, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check(fan_drive, 3'b010, "inverted pwm");
        rd_chk(IDX_DUTY_CH3, 32'h0000_0082, "duty kept through shutdown");
        $display("test shutdown done");

        // unmapped address, then lock freezes both offsets
        apb(1'b0, 8'h10, 32'h0);
        check(er, 1'b1, "unmapped read error");
        check(rd, 32'h0, "unmapped read data");
        apb(1'b1, IDX_LOCK_CTRL, 32'h0000_0003);
        apb(1'b1, IDX_LOCAL_OFFSET, 32'h0000_0055);
        apb(1'b1, IDX_REMOTE2_OFFSET, 32'h0000_00aa);
        rd_chk(IDX_LOCAL_OFFSET, 32'h0000_00fe, "local offset locked");
        rd_chk(IDX_REMOTE2_OFFSET, 32'h0000_0003, "remote2 offset locked");
        $display("test lock done");
        tally_and_finish();
    end
endmodule
